// ===== hdl/acl_regs.vh
// register offsets, field positions and timing constants of the asic control low byte
`ifndef ACL_REGS_VH
`define ACL_REGS_VH

// bus geometry
`define ACL_ADDR_W          8
`define ACL_DATA_W          32
`define ACL_WORD_LSB        2

// register map, byte addresses
`define ACL_ASIC_CONTROL_OFS 8'h30

// asic_control field positions
`define ACL_BIT_ROM_BYPASS  0
`define ACL_BIT_ROM_SIZE    1
`define ACL_BIT_CAP_10M     4
`define ACL_BIT_CAP_100M    5
`define ACL_BIT_CAP_1000M   6
`define ACL_BIT_MEDIA_FIBER 7
`define ACL_LOW_BYTE_W      8

// reset values of the stored fields
`define ACL_RST_ROM_SIZE    1'b0
`define ACL_RST_CAP         1'b0

// axi responses
`define ACL_RESP_OKAY       2'b00
`define ACL_RESP_DECERR     2'b11

// serial eeprom framing
`define ACL_EE_CMD_READ     3'b110
`define ACL_EE_CMD_W        3
`define ACL_EE_ADDR_W       6
`define ACL_EE_OUT_W        9
`define ACL_EE_DATA_W       16
`define ACL_EE_CFG_WORD     6'h00

// serial clock timing
`define ACL_CLK_PERIOD_NS   40
`define ACL_EE_SK_HALF_NS   1000
`define ACL_EE_SK_HALF_CYC  ((`ACL_EE_SK_HALF_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_TICK_CNT_W      8

`endif

// ===== hdl/acl_sync.v
// two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module acl_sync #(
  parameter W = 1
) (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r;
  reg [W-1:0] stable_r;

  // first stage feeds only the second stage
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_r   <= {W{1'b0}};
      stable_r <= {W{1'b0}};
    end else begin
      meta_r   <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule

// ===== hdl/acl_tick_gen.v
// periodic one-cycle tick for the serial eeprom clock
`timescale 1ns/1ps
module acl_tick_gen #(
  parameter                CNT_W = 8,
  parameter [CNT_W-1:0]    PERIOD = 8'd25
) (
  input  wire clk_sys,
  input  wire rst,
  input  wire run,
  output wire tick
);

  reg [CNT_W-1:0] cnt_r;
  reg             tick_r;

  // counter restarts whenever the serial engine idles, so the first half period is full
  always @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt_r  <= {CNT_W{1'b0}};
      tick_r <= 1'b0;
    end else if (cnt_r == PERIOD - 1'b1) begin
      cnt_r  <= {CNT_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule

// ===== hdl/acl_top.v
// asic control low byte: eeprom load at reset and axi4-lite register slave
//
// Function
// - load bits 7..0 from eeprom at reset; only bits 7..4 and 1 are stored, bits 3..2 and 0 read as zero
// - bit 1 read/write option rom size
// - bit 4 read-only 10m capability
// - bit 5 read-only 100m capability
// - bit 6 read-only 1000m capability
// - bit 7 read-only fiber media flag
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acl_regs.vh"
module acl_top #(
  parameter [`ACL_EE_ADDR_W-1:0] CFG_WORD = `ACL_EE_CFG_WORD
) (
  input  wire                      clk_sys,
  input  wire                      rst,
  // axi4-lite slave
  input  wire [`ACL_ADDR_W-1:0]    s_axi_awaddr,
  input  wire [2:0]                s_axi_awprot,
  input  wire                      s_axi_awvalid,
  output wire                      s_axi_awready,
  input  wire [`ACL_DATA_W-1:0]    s_axi_wdata,
  input  wire [`ACL_DATA_W/8-1:0]  s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output wire                      s_axi_wready,
  output wire [1:0]                s_axi_bresp,
  output wire                      s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`ACL_ADDR_W-1:0]    s_axi_araddr,
  input  wire [2:0]                s_axi_arprot,
  input  wire                      s_axi_arvalid,
  output wire                      s_axi_arready,
  output wire [`ACL_DATA_W-1:0]    s_axi_rdata,
  output wire [1:0]                s_axi_rresp,
  output wire                      s_axi_rvalid,
  input  wire                      s_axi_rready,
  // serial configuration eeprom
  output wire                      ee_cs,
  output wire                      ee_sk,
  output wire                      ee_di,
  input  wire                      ee_do,
  // field values to the rest of the controller
  output wire                      option_rom_size_sel,
  output wire                      phy_cap_10m,
  output wire                      phy_cap_100m,
  output wire                      phy_cap_1000m,
  output wire                      phy_media_fiber,
  output wire                      cfg_loaded
);

  // loader states
  localparam [2:0] ST_START = 3'd0;
  localparam [2:0] ST_OUT   = 3'd1;
  localparam [2:0] ST_IN    = 3'd2;
  localparam [2:0] ST_LATCH = 3'd3;
  localparam [2:0] ST_DONE  = 3'd4;

  // integer forms cut to the counter widths on purpose
  localparam integer                SK_HALF_I  = `ACL_EE_SK_HALF_CYC;
  localparam integer                OUT_LAST_I = `ACL_EE_OUT_W - 1;
  localparam integer                IN_LAST_I  = `ACL_EE_DATA_W - 1;
  localparam [`ACL_TICK_CNT_W-1:0]  SK_HALF    = SK_HALF_I[`ACL_TICK_CNT_W-1:0];
  localparam [4:0]                  OUT_LAST   = OUT_LAST_I[4:0];
  localparam [4:0]                  IN_LAST    = IN_LAST_I[4:0];
  localparam [`ACL_EE_CMD_W-1:0]    EE_CMD     = `ACL_EE_CMD_READ;

  // word address match, used by both read and write paths
  function hit_asic_control;
    input [`ACL_ADDR_W-1:0] addr;
    begin
      hit_asic_control = (addr[`ACL_ADDR_W-1:`ACL_WORD_LSB] ==
                          `ACL_ASIC_CONTROL_OFS >> `ACL_WORD_LSB);
    end
  endfunction

  // ---------------------------------------------------------------- eeprom side
  wire ee_do_s;
  wire sk_tick;

  reg  [2:0]                   st_r;
  reg  [4:0]                   bit_cnt_r;
  reg  [`ACL_EE_OUT_W-1:0]     out_sr_r;
  reg  [`ACL_EE_DATA_W-1:0]    in_sr_r;
  reg                          cs_r;
  reg                          sk_r;
  reg                          di_r;
  reg                          loaded_r;

  // data pin comes from another chip, so it is synchronised first
  acl_sync #(
    .W        (1)
  ) u_do_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (ee_do),
    .sync_out (ee_do_s)
  );

  // half-period ticks only while a transfer is in progress
  acl_tick_gen #(
    .CNT_W    (`ACL_TICK_CNT_W),
    .PERIOD   (SK_HALF)
  ) u_sk_tick (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (cs_r),
    .tick     (sk_tick)
  );

  // field storage
  reg rom_size_r;
  reg cap_10m_r;
  reg cap_100m_r;
  reg cap_1000m_r;
  reg media_fiber_r;

  // serial read of one configuration word, started by every reset
  always @(posedge clk_sys) begin
    if (rst) begin
      st_r      <= ST_START;
      bit_cnt_r <= 5'd0;
      out_sr_r  <= {`ACL_EE_OUT_W{1'b0}};
      in_sr_r   <= {`ACL_EE_DATA_W{1'b0}};
      cs_r      <= 1'b0;
      sk_r      <= 1'b0;
      di_r      <= 1'b0;
      loaded_r  <= 1'b0;
    end else begin
      case (st_r)
        ST_START: begin
          // first bit goes out with chip select, rest waits in the shifter
          cs_r      <= 1'b1;
          sk_r      <= 1'b0;
          di_r      <= EE_CMD[`ACL_EE_CMD_W-1];
          out_sr_r  <= {EE_CMD[`ACL_EE_CMD_W-2:0], CFG_WORD, 1'b0};
          bit_cnt_r <= 5'd0;
          st_r      <= ST_OUT;
        end
        ST_OUT: begin
          if (sk_tick) begin
            if (!sk_r) begin
              sk_r <= 1'b1; // eeprom takes di on this rise
            end else begin
              sk_r <= 1'b0;
              if (bit_cnt_r == OUT_LAST) begin
                bit_cnt_r <= 5'd0;
                di_r      <= 1'b0;
                st_r      <= ST_IN;
              end else begin
                bit_cnt_r <= bit_cnt_r + 5'd1;
                di_r      <= out_sr_r[`ACL_EE_OUT_W-1];
                out_sr_r  <= out_sr_r << 1;
              end
            end
          end
        end
        ST_IN: begin
          if (sk_tick) begin
            if (!sk_r) begin
              // sample just before the rise: a full half period after the fall
              sk_r    <= 1'b1;
              in_sr_r <= {in_sr_r[`ACL_EE_DATA_W-2:0], ee_do_s};
            end else begin
              sk_r <= 1'b0;
              if (bit_cnt_r == IN_LAST) begin
                cs_r <= 1'b0;
                st_r <= ST_LATCH;
              end else begin
                bit_cnt_r <= bit_cnt_r + 5'd1;
              end
            end
          end
        end
        ST_LATCH: begin
          loaded_r <= 1'b1;
          st_r     <= ST_DONE;
        end
        ST_DONE: begin
          st_r <= ST_DONE; // nothing until the next reset
        end
        default: begin
          st_r <= ST_START;
        end
      endcase
    end
  end

  assign ee_cs = cs_r;
  assign ee_sk = sk_r;
  assign ee_di = di_r;

  // ---------------------------------------------------------------- axi write path
  reg                        aw_have_r;
  reg  [`ACL_ADDR_W-1:0]     aw_addr_r;
  reg                        w_have_r;
  reg  [`ACL_DATA_W-1:0]     w_data_r;
  reg  [`ACL_DATA_W/8-1:0]   w_strb_r;
  reg                        bvalid_r;
  reg  [1:0]                 bresp_r;

  wire aw_take;
  wire w_take;
  wire wr_go;

  // bus is held off until the eeprom word is in, so nothing sees stale fields
  assign s_axi_awready = loaded_r && !aw_have_r && !bvalid_r;
  assign s_axi_wready  = loaded_r && !w_have_r && !bvalid_r;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_go         = aw_have_r && w_have_r;

  // address and data may arrive in either order
  always @(posedge clk_sys) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= {`ACL_ADDR_W{1'b0}};
      w_have_r  <= 1'b0;
      w_data_r  <= {`ACL_DATA_W{1'b0}};
      w_strb_r  <= {(`ACL_DATA_W/8){1'b0}};
      bvalid_r  <= 1'b0;
      bresp_r   <= `ACL_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= hit_asic_control(aw_addr_r) ? `ACL_RESP_OKAY : `ACL_RESP_DECERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---------------------------------------------------------------- field registers
  // eeprom word wins once at load; only the size select is writable afterwards
  always @(posedge clk_sys) begin
    if (rst) begin
      rom_size_r    <= `ACL_RST_ROM_SIZE;
      cap_10m_r     <= `ACL_RST_CAP;
      cap_100m_r    <= `ACL_RST_CAP;
      cap_1000m_r   <= `ACL_RST_CAP;
      media_fiber_r <= `ACL_RST_CAP;
    end else if (st_r == ST_LATCH) begin
      rom_size_r    <= in_sr_r[`ACL_BIT_ROM_SIZE];
      cap_10m_r     <= in_sr_r[`ACL_BIT_CAP_10M];
      cap_100m_r    <= in_sr_r[`ACL_BIT_CAP_100M];
      cap_1000m_r   <= in_sr_r[`ACL_BIT_CAP_1000M];
      media_fiber_r <= in_sr_r[`ACL_BIT_MEDIA_FIBER];
    end else if (wr_go && hit_asic_control(aw_addr_r) && w_strb_r[0]) begin
      // capability and media bits have no write path at all
      rom_size_r <= w_data_r[`ACL_BIT_ROM_SIZE];
    end
  end

  assign option_rom_size_sel = rom_size_r;
  assign phy_cap_10m         = cap_10m_r;
  assign phy_cap_100m        = cap_100m_r;
  assign phy_cap_1000m       = cap_1000m_r;
  assign phy_media_fiber     = media_fiber_r;
  assign cfg_loaded          = loaded_r;

  // ---------------------------------------------------------------- axi read path
  reg                      rvalid_r;
  reg  [`ACL_DATA_W-1:0]   rdata_r;
  reg  [1:0]               rresp_r;
  reg  [`ACL_DATA_W-1:0]   rd_word;

  wire ar_take;

  assign s_axi_arready = loaded_r && !rvalid_r;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  // reserved bits and the upper bytes read as zero; software ignores them anyway
  always @* begin
    rd_word                       = {`ACL_DATA_W{1'b0}};
    rd_word[`ACL_BIT_ROM_SIZE]    = rom_size_r;
    rd_word[`ACL_BIT_CAP_10M]     = cap_10m_r;
    rd_word[`ACL_BIT_CAP_100M]    = cap_100m_r;
    rd_word[`ACL_BIT_CAP_1000M]   = cap_1000m_r;
    rd_word[`ACL_BIT_MEDIA_FIBER] = media_fiber_r;
  end

  // one read at a time, data registered with the response
  always @(posedge clk_sys) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= {`ACL_DATA_W{1'b0}};
      rresp_r  <= `ACL_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      if (hit_asic_control(s_axi_araddr)) begin
        rdata_r <= rd_word;
        rresp_r <= `ACL_RESP_OKAY;
      end else begin
        rdata_r <= {`ACL_DATA_W{1'b0}};
        rresp_r <= `ACL_RESP_DECERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule

// ===== sim/acl_ee_model.sv
// serial configuration eeprom model answering one word read
`timescale 1ns/1ps
module acl_ee_model (
  input  wire        ee_cs,
  input  wire        ee_sk,
  input  wire        ee_di,
  input  wire [15:0] word,
  output logic       ee_do,
  output logic [8:0] cmd
);
  int n = 0;
  initial cmd = 9'h000;
  // count serial clock rises within one frame, command bits taken on the first nine
  always @(posedge ee_sk or negedge ee_cs)
    if (!ee_cs) n <= 0;
    else begin
      n <= n + 1;
      if (n < 9) cmd <= {cmd[7:0], ee_di};
    end
  // msb first after the ninth fall; elsewhere the line toggles, never the old bit
  initial ee_do = 1'b0;
  always @(negedge ee_sk or negedge ee_cs)
    if (ee_cs && n >= 9 && n < 25) ee_do <= word[24-n];
    else ee_do <= ~ee_do;
endmodule

// ===== sim/acl_top_asserts.sv
// concurrent checks on the asic control low byte ports
`timescale 1ns/1ps
module acl_top_asserts (
  input wire        clk_sys,
  input wire        rst,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        ee_cs,
  input wire        option_rom_size_sel,
  input wire        phy_cap_10m,
  input wire        phy_cap_100m,
  input wire        phy_cap_1000m,
  input wire        phy_media_fiber,
  input wire        cfg_loaded
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // read-only flags as they sit in bits 7..4
  wire [3:0] ro = {phy_media_fiber, phy_cap_1000m, phy_cap_100m, phy_cap_10m};
  property p_hold; !cfg_loaded |-> !s_axi_awready && !s_axi_wready && !s_axi_arready; endproperty
  a_hold: assert property (p_hold) else $error("bus taken before load");
  // cycles spent loading; a frame takes about 1260, so reaching the limit means the load hung
  localparam int LOAD_MAX = 1400;
  int load_cnt = 0;
  always @(posedge clk_sys)
    if (rst || cfg_loaded) load_cnt <= 0;
    else if (load_cnt < LOAD_MAX) load_cnt <= load_cnt + 1;
  property p_load; $fell(rst) |=> ee_cs; endproperty
  a_load: assert property (p_load) else $error("eeprom not selected after reset");
  property p_load_time; load_cnt < LOAD_MAX; endproperty
  a_load_time: assert property (p_load_time) else $error("load not finished in time");
  property p_stay; cfg_loaded |=> cfg_loaded; endproperty
  a_stay: assert property (p_stay) else $error("load flag dropped");
  property p_cs_off; cfg_loaded |-> !ee_cs; endproperty
  a_cs_off: assert property (p_cs_off) else $error("eeprom selected after load");
  property p_ro; cfg_loaded |=> $stable(ro); endproperty
  a_ro: assert property (p_ro) else $error("read-only flag changed");
  property p_rd;
    $rose(s_axi_rvalid) && !s_axi_bvalid && s_axi_rresp == 2'b00
      |-> s_axi_rdata == {24'h0, ro, 2'b00, option_rom_size_sel, 1'b0};
  endproperty
  a_rd: assert property (p_rd) else $error("read data differs from fields");
  property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_one: assert property (p_b_one) else $error("write answer repeated");
  property p_r_one; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_one: assert property (p_r_one) else $error("read answer repeated");
  property p_w_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_blk: assert property (p_w_blk) else $error("write taken while answer pending");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("read taken while answer pending");
  c_load: cover property ($rose(cfg_loaded));
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property ($rose(s_axi_rvalid) && s_axi_rresp == 2'b11);
endmodule
bind acl_top acl_top_asserts u_chk (.clk_sys, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ee_cs,
  .option_rom_size_sel, .phy_cap_10m, .phy_cap_100m, .phy_cap_1000m, .phy_media_fiber, .cfg_loaded);

// ===== sim/test_asic_control_low_byte.sv
// self-checking bench: eeprom load, register reads and writes over axi4-lite
`timescale 1ns/1ps
module test_asic_control_low_byte;
  logic        clk_sys = 0, rst = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, seed;
  logic [3:0]  s_axi_wstrb = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ee_cs, ee_sk, ee_do, ee_di;
  wire [8:0]   ee_cmd;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         option_rom_size_sel, phy_cap_10m, phy_cap_100m, phy_cap_1000m, phy_media_fiber, cfg_loaded;
  wire [4:0]   fld = {phy_media_fiber, phy_cap_1000m, phy_cap_100m, phy_cap_10m, option_rom_size_sel};
  logic [15:0] w = 0;
  logic [7:0]  e;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          n_fail = 0, n_tests = 0;

  acl_top u_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ee_cs, .ee_sk, .ee_di, .ee_do, .option_rom_size_sel, .phy_cap_10m,
    .phy_cap_100m, .phy_cap_1000m, .phy_media_fiber, .cfg_loaded);
  acl_ee_model u_ee (.ee_cs, .ee_sk, .ee_di, .word(w), .ee_do, .cmd(ee_cmd));

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic rep(input logic [33:0] g, x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk_r(input logic [33:0] g, x); rep(g, x); endtask
  task automatic chk_b(input logic [1:0] g, x); rep({32'h0, g}, {32'h0, x}); endtask
  task automatic chk_f(input logic [4:0] g, x); rep({29'h0, g}, {29'h0, x}); endtask
  task automatic chk_c(input logic [8:0] g, x); rep({25'h0, g}, {25'h0, x}); endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ha, hw, hb;
    bq.push_back(r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      @(posedge clk_sys);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    logic hr, hb;
    rq.push_back(x);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge clk_sys);
      hr = s_axi_arvalid && s_axi_arready;
      hb = s_axi_rvalid;
      @(posedge clk_sys);
      if (hr) s_axi_arvalid <= 1'b0;
    end while (!hb);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // answers are sampled mid-cycle, where they are settled
  always @(negedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) chk_r({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk_b(s_axi_bresp, bq.pop_front());
  end

  // second pass uses the inverse word so every flag is seen at both levels
  initial begin
    seed = 32'h24c5;
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      w = k ? ~w : seed[15:0];
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      e = {w[7:4], 2'b00, w[1], 1'b0};
      rd(8'h30, {2'b00, 24'h0, e});
      chk_f(fld, {e[7:4], e[1]});
      // read command 110 for configuration word 0, as the eeprom saw it
      chk_c(ee_cmd, 9'h180);
      // reserved bits always written as zero
      wr(8'h30, ~{24'h0, e} & 32'hffff_fff2, 4'hf, 2'b00);
      e[1] = ~e[1];
      chk_f(fld, {e[7:4], e[1]});
      // lane zero not enabled: nothing moves
      wr(8'h30, ~{24'h0, e} & 32'hffff_fff2, 4'he, 2'b00);
      rd(8'h30, {2'b00, 24'h0, e});
      wr(8'h34, 32'hffff_fff2, 4'hf, 2'b11);
      rd(8'h34, {2'b11, 32'h0});
      for (int i = 0; i < 4; i++) begin
        seed = xs(seed);
        wr(8'h30, seed & 32'hffff_fff2, 4'h1, 2'b00);
        e[1] = seed[1];
        rd(8'h30, {2'b00, 24'h0, e});
      end
    end
    test_done;
  end

  // two loads and a few dozen transfers fit well inside this
  initial begin
    repeat (10000) @(posedge clk_sys);
    n_fail++;
    test_done;
  end
endmodule
